// File: hdl/iciq_regs.sv
// Register block: relay readback, input levels, change watch and interrupts.
`timescale 1ns/1ps

module iciq_regs #(
  parameter int CHANNELS = 16
) (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                reset,
  // Local register port from the bridge
  input  wire logic [3:0]          lb_addr,
  input  wire logic                lb_wr,
  input  wire logic                lb_rd,
  input  wire logic [15:0]         lb_wdata,
  output logic      [15:0]         lb_rdata,
  output logic                     lb_rvalid,
  // Field pins
  input  wire logic [CHANNELS-1:0] relay_state_bit,
  input  wire logic [CHANNELS-1:0] iso_input_bit,
  // Interrupt request to the bridge
  output logic                     irq_req
);

  if (CHANNELS != 16) begin : g_width_check
    $error("CHANNELS must be 16 to fit the 16-bit registers.");
  end
  default clocking cb_ref @(posedge ref_clk); endclocking
  default disable iff (reset);

  localparam int NSYNC = 2 * CHANNELS;
  localparam logic [4:0] DIV_LAST = 5'(iciq_pkg::SAMPLE_DIV - 1);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [NSYNC-1:0] pins;
  logic [NSYNC-1:0] s1_q, s2_q, s3_q, lvl_q;
  logic [NSYNC-1:0] s1_d, s2_d, s3_d, lvl_d;

  assign pins = {relay_state_bit, iso_input_bit};

  // A level is taken only once the second and third stages agree.
  for (genvar i = 0; i < NSYNC; i++) begin : g_sync
    always_comb begin
      s1_d[i]  = pins[i];
      s2_d[i]  = s1_q[i];
      s3_d[i]  = s2_q[i];
      lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      lvl_q <= '0;
    end else begin
      s1_q  <= s1_d;
      s2_q  <= s2_d;
      s3_q  <= s3_d;
      lvl_q <= lvl_d;
    end
  end

  logic [15:0] relays, inputs;
  assign inputs = lvl_q[CHANNELS-1:0];
  assign relays = lvl_q[NSYNC-1:CHANNELS];

  // ---------------------------------------------------------------
  // Sample rate divider
  // ---------------------------------------------------------------
  logic [4:0] div_q, div_d;
  logic       tick_q, tick_d;

  always_comb begin
    div_d  = (div_q == DIV_LAST) ? 5'h00 : div_q + 5'h01;
    tick_d = (div_q == DIV_LAST);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      div_q  <= 5'h00;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  logic [15:0] watch_q, watch_d;
  logic [2:0]  en_q, en_d;
  logic [2:0]  clr;
  logic        wr_watch, wr_ctrl;
  iciq_pkg::iciq_mode_t mode;

  assign wr_watch = lb_wr && (lb_addr == iciq_pkg::OFS_CHANGE_WATCH);
  assign wr_ctrl  = lb_wr && (lb_addr == iciq_pkg::OFS_IRQ_CTRL);

  always_comb begin
    watch_d = wr_watch ? lb_wdata : watch_q;
    en_d    = en_q;
    if (wr_ctrl) begin
      en_d = {lb_wdata[iciq_pkg::BIT_IN1_EN],
              lb_wdata[iciq_pkg::BIT_IN0_EN],
              lb_wdata[iciq_pkg::BIT_CHANGE_EN]};
    end
    // Writing zero to a clear bit leaves the request alone.
    clr = wr_ctrl ? {lb_wdata[iciq_pkg::BIT_IN1_CLR],
                     lb_wdata[iciq_pkg::BIT_IN0_CLR],
                     lb_wdata[iciq_pkg::BIT_CHANGE_CLR]}
                  : 3'h0;
    // A change enable mixed with an edge enable counts as disabled.
    unique case (en_q)
      3'b001:                 mode = iciq_pkg::MODE_CHANGE;
      3'b010, 3'b100, 3'b110: mode = iciq_pkg::MODE_EDGE;
      default:                mode = iciq_pkg::MODE_OFF;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      watch_q <= iciq_pkg::RST_WORD;
      en_q    <= iciq_pkg::RST_FLAGS;
    end else begin
      watch_q <= watch_d;
      en_q    <= en_d;
    end
  end

  // ---------------------------------------------------------------
  // Sampling and event detection
  // ---------------------------------------------------------------
  logic [15:0] samp_q, samp_d;
  logic        primed_q, primed_d;
  logic        chg_ev, in0_ev, in1_ev;

  always_comb begin
    samp_d   = tick_q ? inputs : samp_q;
    primed_d = primed_q | tick_q;
  end

  // The first sample only seeds the history, so no edge is invented.
  assign chg_ev = tick_q && primed_q && (mode == iciq_pkg::MODE_CHANGE)
                  && |((inputs ^ samp_q) & watch_q);
  assign in0_ev = tick_q && primed_q && (mode == iciq_pkg::MODE_EDGE)
                  && en_q[1] && inputs[0] && !samp_q[0];
  assign in1_ev = tick_q && primed_q && (mode == iciq_pkg::MODE_EDGE)
                  && en_q[2] && inputs[1] && !samp_q[1];

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      samp_q   <= iciq_pkg::RST_WORD;
      primed_q <= 1'b0;
    end else begin
      samp_q   <= samp_d;
      primed_q <= primed_d;
    end
  end

  // ---------------------------------------------------------------
  // Pending requests and snapshot
  // ---------------------------------------------------------------
  logic [2:0]  pend_q, pend_d;
  logic [15:0] snap_q, snap_d;
  logic        irq_d;

  // A new event wins over a clear that lands in the same cycle.
  always_comb begin
    pend_d = (pend_q & ~clr) | {in1_ev, in0_ev, chg_ev};
    snap_d = snap_q;
    if (clr[0]) begin
      snap_d = iciq_pkg::RST_WORD;
    end
    if (chg_ev) begin
      snap_d = inputs;
    end
    irq_d = |pend_d;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pend_q  <= iciq_pkg::RST_FLAGS;
      snap_q  <= iciq_pkg::RST_WORD;
      irq_req <= 1'b0;
    end else begin
      pend_q  <= pend_d;
      snap_q  <= snap_d;
      irq_req <= irq_d;
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  logic [15:0] rdata_d;
  logic        rvalid_d;

  // Each register is one 16-bit word; unmapped offsets read zero.
  always_comb begin
    rdata_d  = lb_rdata;
    rvalid_d = lb_rd;
    if (lb_rd) begin
      unique case (lb_addr)
        iciq_pkg::OFS_RELAY_READBACK: rdata_d = relays;
        iciq_pkg::OFS_INPUT_LEVELS:   rdata_d = inputs;
        iciq_pkg::OFS_CHANGE_WATCH:   rdata_d = snap_q;
        iciq_pkg::OFS_IRQ_CTRL:
          rdata_d = {5'h00, en_q, 5'h00, pend_q};
        default:                      rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lb_rdata  <= 16'h0000;
      lb_rvalid <= 1'b0;
    end else begin
      lb_rdata  <= rdata_d;
      lb_rvalid <= rvalid_d;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_change_event;
    chg_ev && !clr[0];
  endsequence

  sequence s_change_taken;
    pend_q[0] && irq_req;
  endsequence

  a_change_sets_pend: assert property (
    s_change_event |=> s_change_taken)
    else $error("Change event did not raise the request.");

  a_snapshot_capture: assert property (
    chg_ev |=> snap_q == $past(inputs))
    else $error("Snapshot does not hold the inputs at the event.");

  a_snapshot_clear: assert property (
    (clr[0] && !chg_ev) |=> (snap_q == 16'h0000) && !pend_q[0])
    else $error("Clearing the change request left state behind.");

  a_edge_in0: assert property (
    (tick_q && primed_q && en_q == 3'b010 && inputs[0] && !samp_q[0])
    |=> pend_q[1] && irq_req)
    else $error("Rising edge of input 0 was not flagged.");

  a_edge_falls: assert property (
    (mode == iciq_pkg::MODE_EDGE && pend_q[2:1] == 2'b00 && !in0_ev && !in1_ev)
    |=> pend_q[2:1] == 2'b00)
    else $error("Edge request raised without a rising edge.");

  a_mode_quiet: assert property (
    (mode == iciq_pkg::MODE_OFF && pend_q == 3'h0) |=> pend_q == 3'h0)
    else $error("Request raised while interrupts are disabled.");

  a_pend_hold: assert property (
    (pend_q[0] && !clr[0]) |=> pend_q[0] && irq_req)
    else $error("Pending change request dropped without a clear.");

  a_status_read: assert property (
    (lb_rd && lb_addr == iciq_pkg::OFS_IRQ_CTRL)
    |=> lb_rvalid && lb_rdata[2:0] == $past(pend_q)
        && lb_rdata[10:8] == $past(en_q))
    else $error("Status read does not show pending and enables.");

  a_tick_spacing: assert property (
    tick_q |=> !tick_q [*8])
    else $error("Sample ticks come too close together.");

endmodule

// File: common/iciq_pkg.sv
// Constants of the isolated-input change and interrupt register block.
package iciq_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] OFS_RELAY_READBACK = 4'h2;
  localparam logic [3:0] OFS_INPUT_LEVELS   = 4'h4;
  localparam logic [3:0] OFS_CHANGE_WATCH   = 4'h6;
  localparam logic [3:0] OFS_IRQ_CTRL       = 4'h8;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_CHANGE_CLR = 0;
  localparam int BIT_IN0_CLR    = 1;
  localparam int BIT_IN1_CLR    = 2;
  localparam int BIT_CHANGE_EN  = 8;
  localparam int BIT_IN0_EN     = 9;
  localparam int BIT_IN1_EN     = 10;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [2:0]  RST_FLAGS = 3'h0;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ      = 250000000;
  localparam int SAMPLE_HZ   = 8250000;
  localparam int SAMPLE_DIV  = CLK_HZ / SAMPLE_HZ;

  typedef enum logic [1:0] {
    MODE_OFF    = 2'b00,
    MODE_CHANGE = 2'b01,
    MODE_EDGE   = 2'b11
  } iciq_mode_t;

endpackage

// File: dv/iciq_bridge_model.sv
// Bridge local-bus model that issues whole-word register reads and writes.
`timescale 1ns/1ps

module iciq_bridge_model (
  // Clock
  input  wire logic        ref_clk,
  // Local register port
  output logic [3:0]       lb_addr,
  output logic             lb_wr,
  output logic             lb_rd,
  output logic [15:0]      lb_wdata,
  input  wire logic [15:0] lb_rdata,
  input  wire logic        lb_rvalid
);
  initial begin
    lb_addr  = 4'h0;
    lb_wr    = 1'b0;
    lb_rd    = 1'b0;
    lb_wdata = 16'h0000;
  end

  // Released lines show inverted values so stale data never looks valid.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    lb_addr  = a;
    lb_wdata = d;
    lb_wr    = 1'b1;
    @(posedge ref_clk);
    #1;
    lb_wr    = 1'b0;
    lb_addr  = ~a;
    lb_wdata = ~d;
    @(posedge ref_clk);
    #1;
  endtask

  // The address stands until the answer is taken; the strobe is one cycle.
  task automatic rd(input logic [3:0] a, output logic [15:0] d,
                    output logic ok);
    d       = 16'h0000;
    ok      = 1'b0;
    lb_addr = a;
    lb_rd   = 1'b1;
    @(posedge ref_clk);
    #1;
    lb_rd   = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (lb_rvalid === 1'b1) begin
        d  = lb_rdata;
        ok = 1'b1;
        break;
      end
      @(posedge ref_clk);
      #1;
    end
    lb_addr = ~a;
    @(posedge ref_clk);
    #1;
  endtask
endmodule

// File: dv/isolated_input_cos_irq_regs_test.sv
// Self-checking testbench of the input change and interrupt register block.
`timescale 1ns/1ps

module isolated_input_cos_irq_regs_test;
  logic        ref_clk;
  logic        reset;
  logic [15:0] relay;
  logic [15:0] iso;
  logic [3:0]  lb_addr;
  logic        lb_wr;
  logic        lb_rd;
  logic [15:0] lb_wdata;
  logic [15:0] lb_rdata;
  logic        lb_rvalid;
  logic        irq_req;
  int          miscompares;
  int          total_checks;

  iciq_bridge_model bus (.ref_clk(ref_clk), .lb_addr(lb_addr), .lb_wr(lb_wr),
    .lb_rd(lb_rd), .lb_wdata(lb_wdata), .lb_rdata(lb_rdata),
    .lb_rvalid(lb_rvalid));

  iciq_regs dut (.ref_clk(ref_clk), .reset(reset), .lb_addr(lb_addr),
    .lb_wr(lb_wr), .lb_rd(lb_rd), .lb_wdata(lb_wdata), .lb_rdata(lb_rdata),
    .lb_rvalid(lb_rvalid), .relay_state_bit(relay), .iso_input_bit(iso),
    .irq_req(irq_req));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic complete_run;
    if (miscompares == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      miscompares++;
    end
  endtask

  task automatic rdchk(logic [3:0] a, logic [15:0] exp, string name);
    logic [15:0] v;
    logic        ok;
    bus.rd(a, v, ok);
    if (!ok) begin
      $display("[FAIL] %s expected lb_rvalid 1 seen 0", name);
      miscompares++;
      complete_run();
    end else begin
      chk(name, exp, v);
    end
  endtask

  task automatic step(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic irq_is(logic exp);
    chk("irq_req", {15'h0000, exp}, {15'h0000, irq_req});
  endtask

  // Waits for the request line; a lapsed bound ends the run.
  task automatic wait_irq(logic exp);
    for (int i = 0; i < 200; i++) begin
      if (irq_req === exp) begin
        total_checks++;
        return;
      end
      step(1);
    end
    $display("[FAIL] irq_req expected %b seen %b", exp, irq_req);
    miscompares++;
    complete_run();
  endtask

  task automatic t_read;
    rdchk(4'h2, 16'hA5C3, "relay_state_readback");
    rdchk(4'h4, 16'h3C5A, "isolated_input_levels");
    rdchk(4'hA, 16'h0000, "unmapped");
  endtask

  task automatic t_change;
    bus.wr(4'h6, 16'h0008);
    bus.wr(4'h8, 16'h0100);
    rdchk(4'h8, 16'h0100, "irq_status");
    iso = 16'h3C4A;
    step(80);
    irq_is(1'b0);
    iso = 16'h3C42;
    wait_irq(1'b1);
    rdchk(4'h6, 16'h3C42, "change_snapshot");
    rdchk(4'h8, 16'h0101, "irq_status");
    bus.wr(4'h8, 16'h0100);
    step(40);
    irq_is(1'b1);
    bus.wr(4'h8, 16'h0101);
    wait_irq(1'b0);
    rdchk(4'h6, 16'h0000, "change_snapshot");
  endtask

  task automatic t_edge;
    bus.wr(4'h8, 16'h0600);
    iso = 16'h3C40;
    step(80);
    irq_is(1'b0);
    iso = 16'h3C41;
    wait_irq(1'b1);
    rdchk(4'h8, 16'h0602, "irq_status");
    bus.wr(4'h8, 16'h0602);
    wait_irq(1'b0);
    iso = 16'h3C43;
    wait_irq(1'b1);
    rdchk(4'h8, 16'h0604, "irq_status");
    bus.wr(4'h8, 16'h0604);
    wait_irq(1'b0);
    bus.wr(4'h8, 16'h0200);
    iso = 16'h3C40;
    step(80);
    iso = 16'h3C42;
    step(80);
    irq_is(1'b0);
    iso = 16'h3C43;
    wait_irq(1'b1);
    rdchk(4'h8, 16'h0202, "irq_status");
    bus.wr(4'h8, 16'h0202);
    wait_irq(1'b0);
    bus.wr(4'h8, 16'h0400);
    iso = 16'h3C40;
    step(80);
    iso = 16'h3C41;
    step(80);
    irq_is(1'b0);
    iso = 16'h3C43;
    wait_irq(1'b1);
    rdchk(4'h8, 16'h0404, "irq_status");
    bus.wr(4'h8, 16'h0404);
    wait_irq(1'b0);
  endtask

  task automatic t_off;
    logic [15:0] ens [4] = '{16'h0700, 16'h0300, 16'h0500, 16'h0000};
    for (int k = 0; k < 4; k++) begin
      bus.wr(4'h8, ens[k]);
      iso = 16'h3C40;
      step(40);
      iso = 16'h3C4B;
      step(80);
      irq_is(1'b0);
      rdchk(4'h8, ens[k], "irq_status");
    end
  endtask

  initial begin
    reset        = 1'b1;
    relay        = 16'hA5C3;
    iso          = 16'h3C5A;
    miscompares  = 0;
    total_checks = 0;
    step(5);
    reset = 1'b0;
    step(80);
    t_read();
    t_change();
    t_edge();
    t_off();
    complete_run();
  end
endmodule
